/* shared/jrmd_pkg.sv */
// Constants and types shared by both ends of the jog and registration move link.
// Overview of operation
// - Opcode 0080 requests clockwise jog with parameters.
// - Opcode 0100 requests counter-clockwise jog, same layout.
// - Host clears mode bits 7:6 for jog.
// - Host sets mode bits 7:6 to 10 for registration.
// - Registration direction comes from the opcode word.
// - Speed words 4:5, starting speed to 2999999.
// - Jog current word 8 used only if bit 1.
// - Stopping distance words 2:3, 0 to 8388607.
// - Minimum registration distance words 8:9, same range.
// - Registration accel/decel words 6,7; 1 to 5000.
// - Jog words 2 and 3 are ignored.
package jrmd_pkg;
    localparam int WORD_W = 16;
    localparam int NUM_WORDS = 10;
    typedef logic [NUM_WORDS-1:0][WORD_W-1:0] jrmd_words_t;
    // Word positions within a command block.
    localparam int W_OPCODE = 0;
    localparam int W_MODE = 1;
    localparam int W_STOP_HI = 2;
    localparam int W_STOP_LO = 3;
    localparam int W_SPEED_HI = 4;
    localparam int W_SPEED_LO = 5;
    localparam int W_ACCEL = 6;
    localparam int W_DECEL = 7;
    localparam int W_CURRENT = 8;
    localparam int W_JERK = 9;
    localparam int W_MINREG_HI = 8;
    localparam int W_MINREG_LO = 9;
    // Opcodes and mode bit fields.
    localparam logic [15:0] OP_JOG_CW = 16'h0080;
    localparam logic [15:0] OP_JOG_CCW = 16'h0100;
    localparam int MODE_SEL_HI = 7;
    localparam int MODE_SEL_LO = 6;
    localparam int MODE_CUR_BIT = 1;
    localparam logic [1:0] MODE_JOG = 2'h0;
    localparam logic [1:0] MODE_REG = 2'h2;
    // Parameter ranges.
    localparam logic [31:0] SPEED_MAX = 32'h002DC6BF;
    localparam logic [15:0] RATE_MIN = 16'h0001;
    localparam logic [15:0] RATE_MAX = 16'h1388;
    localparam logic [15:0] CUR_MIN = 16'h0001;
    localparam logic [15:0] CUR_MAX = 16'h0014;
    localparam logic [15:0] JERK_MAX = 16'h1388;
    localparam logic [31:0] DIST_MAX = 32'h007FFFFF;
    localparam logic [31:0] START_SPEED_DEF = 32'h00000064;
endpackage

/* shared/jrmd_if.sv */
// Link between the command source and the move decoder.
`timescale 1ns/1ps
interface jrmd_if;
    import jrmd_pkg::*;
    logic        cmd_valid;
    jrmd_words_t cmd_words;
    logic        resp_valid;
    logic        resp_err;
    logic        resp_move;
    modport host (output cmd_valid, output cmd_words,
                  input resp_valid, input resp_err, input resp_move);
    modport dev (input cmd_valid, input cmd_words,
                 output resp_valid, output resp_err, output resp_move);
endinterface

/* src/jrmd_range_check.sv */
// Range checker for the parameter words of one jog or registration block.
`timescale 1ns/1ps
module jrmd_range_check
    import jrmd_pkg::*;
(
    // Command block under test
    input  wire jrmd_pkg::jrmd_words_t words,
    input  wire logic                  is_reg,
    input  wire logic [31:0]           start_speed,
    // Verdict
    output logic                       range_ok
);
    import jrmd_pkg::*;

    logic [31:0] speed;
    logic [31:0] stop_dist;
    logic [31:0] min_dist;
    logic        speed_ok;
    logic        rates_ok;
    logic        cur_ok;
    logic        jerk_ok;
    logic        dist_ok;

    assign speed = {words[W_SPEED_HI], words[W_SPEED_LO]};
    assign stop_dist = {words[W_STOP_HI], words[W_STOP_LO]};
    assign min_dist = {words[W_MINREG_HI], words[W_MINREG_LO]};

    assign speed_ok = (speed >= start_speed) && (speed <= SPEED_MAX);
    assign rates_ok = (words[W_ACCEL] >= RATE_MIN) && (words[W_ACCEL] <= RATE_MAX)
                   && (words[W_DECEL] >= RATE_MIN) && (words[W_DECEL] <= RATE_MAX);
    // A negative distance reads as a large unsigned value and fails here.
    assign dist_ok = (stop_dist <= DIST_MAX) && (min_dist <= DIST_MAX);
    assign cur_ok = !words[W_MODE][MODE_CUR_BIT]
                 || ((words[W_CURRENT] >= CUR_MIN) && (words[W_CURRENT] <= CUR_MAX));
    assign jerk_ok = words[W_JERK] <= JERK_MAX;

    always_comb begin
        if (is_reg) begin
            range_ok = speed_ok && rates_ok && dist_ok;
        end else begin
            // Words 2 and 3 play no part in a jog verdict.
            range_ok = speed_ok && rates_ok && cur_ok && jerk_ok;
        end
    end
endmodule

/* src/jrmd_device.sv */
// Device end: decodes jog and registration command blocks into move orders.
`timescale 1ns/1ps
module jrmd_device
    import jrmd_pkg::*;
(
    // Clock and reset
    input  wire  logic        ref_clk,
    input  wire  logic        rst,
    // Link to the command source
    jrmd_if.dev               link,
    // Configuration
    input  wire  logic [31:0] start_speed,
    // Move order to the profile generator
    output logic              move_start,
    output logic              move_ccw,
    output logic              move_is_reg,
    output logic [31:0]       move_speed,
    output logic [15:0]       move_accel,
    output logic [15:0]       move_decel,
    output logic              move_cur_en,
    output logic [15:0]       move_current,
    output logic [15:0]       move_jerk,
    output logic [31:0]       move_stop_dist,
    output logic [31:0]       move_min_dist,
    // Status
    output logic              cmd_error
);
    import jrmd_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_CHECK = 2'b01,
        S_ANSWER = 2'b10
    } jrmd_state_t;

    jrmd_state_t state_ff;
    jrmd_state_t nxt_state;
    jrmd_words_t words_ff;
    logic [31:0] start_speed_ff;
    logic        range_ok;
    logic        op_cw;
    logic        op_ccw;
    logic        mode_jog;
    logic        mode_reg;
    logic        is_ours;
    logic        verdict_ok_ff;
    logic        verdict_ours_ff;
    logic        resp_valid_ff;
    logic        resp_err_ff;
    logic        resp_move_ff;
    logic        move_start_ff;
    logic        move_ccw_ff;
    logic        move_is_reg_ff;
    logic [31:0] move_speed_ff;
    logic [15:0] move_accel_ff;
    logic [15:0] move_decel_ff;
    logic        move_cur_en_ff;
    logic [15:0] move_current_ff;
    logic [15:0] move_jerk_ff;
    logic [31:0] move_stop_dist_ff;
    logic [31:0] move_min_dist_ff;
    logic        cmd_error_ff;
    logic        accept;

    // Opcode and mode decode of the captured block.
    assign op_cw = words_ff[W_OPCODE] == OP_JOG_CW;
    assign op_ccw = words_ff[W_OPCODE] == OP_JOG_CCW;
    assign mode_jog = words_ff[W_MODE][MODE_SEL_HI:MODE_SEL_LO] == MODE_JOG;
    assign mode_reg = words_ff[W_MODE][MODE_SEL_HI:MODE_SEL_LO] == MODE_REG;
    assign is_ours = op_cw || op_ccw;

    jrmd_range_check u_check (
        .words       (words_ff),
        .is_reg      (mode_reg),
        .start_speed (start_speed_ff),
        .range_ok    (range_ok)
    );

    // The block is taken whole in one cycle so later host writes cannot tear it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            words_ff <= '0;
        end else if (state_ff == S_IDLE && link.cmd_valid) begin
            words_ff <= link.cmd_words;
        end
    end

    // The starting speed is sampled with the block so one verdict sees one limit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            start_speed_ff <= START_SPEED_DEF;
        end else if (state_ff == S_IDLE && link.cmd_valid) begin
            start_speed_ff <= start_speed;
        end
    end

    always_comb begin
        case (state_ff)
            S_IDLE: begin
                nxt_state = link.cmd_valid ? S_CHECK : S_IDLE;
            end
            S_CHECK: begin
                nxt_state = S_ANSWER;
            end
            S_ANSWER: begin
                nxt_state = S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // A jog opcode with mode pattern 01 or 11 is neither move and is refused.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            verdict_ok_ff   <= 1'b0;
            verdict_ours_ff <= 1'b0;
        end else if (state_ff == S_CHECK) begin
            verdict_ours_ff <= is_ours;
            verdict_ok_ff   <= (mode_jog || mode_reg) && range_ok;
        end
    end

    assign accept = verdict_ours_ff && verdict_ok_ff;

    // Answer on the link: one pulse per command block.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resp_valid_ff <= 1'b0;
            resp_err_ff   <= 1'b0;
            resp_move_ff  <= 1'b0;
        end else begin
            resp_valid_ff <= state_ff == S_ANSWER;
            resp_err_ff   <= state_ff == S_ANSWER && verdict_ours_ff && !verdict_ok_ff;
            resp_move_ff  <= state_ff == S_ANSWER && accept;
        end
    end

    // The error flag stands until the next block of ours is judged.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_error_ff <= 1'b0;
        end else if (state_ff == S_ANSWER && verdict_ours_ff) begin
            cmd_error_ff <= !verdict_ok_ff;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_start_ff <= 1'b0;
        end else begin
            move_start_ff <= state_ff == S_ANSWER && accept;
        end
    end

    // Move parameters load only for an accepted block; a refused one leaves them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_ccw_ff       <= 1'b0;
            move_is_reg_ff    <= 1'b0;
            move_speed_ff     <= '0;
            move_accel_ff     <= '0;
            move_decel_ff     <= '0;
        end else if (state_ff == S_ANSWER && accept) begin
            move_ccw_ff       <= op_ccw;
            move_is_reg_ff    <= mode_reg;
            move_speed_ff     <= {words_ff[W_SPEED_HI], words_ff[W_SPEED_LO]};
            move_accel_ff     <= words_ff[W_ACCEL];
            move_decel_ff     <= words_ff[W_DECEL];
        end
    end

    // Jog-only fields; a registration block zeroes them as it carries none.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_cur_en_ff  <= 1'b0;
            move_current_ff <= '0;
            move_jerk_ff    <= '0;
        end else if (state_ff == S_ANSWER && accept) begin
            if (mode_reg) begin
                move_cur_en_ff  <= 1'b0;
                move_current_ff <= '0;
                move_jerk_ff    <= '0;
            end else begin
                move_cur_en_ff  <= words_ff[W_MODE][MODE_CUR_BIT];
                move_current_ff <= words_ff[W_MODE][MODE_CUR_BIT]
                                   ? words_ff[W_CURRENT] : 16'h0000;
                move_jerk_ff    <= words_ff[W_JERK];
            end
        end
    end

    // Registration-only fields; for a jog words 2 and 3 never reach an output.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_stop_dist_ff <= '0;
            move_min_dist_ff  <= '0;
        end else if (state_ff == S_ANSWER && accept) begin
            if (mode_reg) begin
                move_stop_dist_ff <= {words_ff[W_STOP_HI], words_ff[W_STOP_LO]};
                move_min_dist_ff  <= {words_ff[W_MINREG_HI], words_ff[W_MINREG_LO]};
            end else begin
                move_stop_dist_ff <= '0;
                move_min_dist_ff  <= '0;
            end
        end
    end

    assign link.resp_valid = resp_valid_ff;
    assign link.resp_err   = resp_err_ff;
    assign link.resp_move  = resp_move_ff;
    assign move_start      = move_start_ff;
    assign move_ccw        = move_ccw_ff;
    assign move_is_reg     = move_is_reg_ff;
    assign move_speed      = move_speed_ff;
    assign move_accel      = move_accel_ff;
    assign move_decel      = move_decel_ff;
    assign move_cur_en     = move_cur_en_ff;
    assign move_current    = move_current_ff;
    assign move_jerk       = move_jerk_ff;
    assign move_stop_dist  = move_stop_dist_ff;
    assign move_min_dist   = move_min_dist_ff;
    assign cmd_error       = cmd_error_ff;
endmodule

/* src/jrmd_host.sv */
// Host end: builds jog and registration command blocks and waits for the answer.
`timescale 1ns/1ps
module jrmd_host
    import jrmd_pkg::*;
(
    // Clock and reset
    input  wire  logic        ref_clk,
    input  wire  logic        rst,
    // Link to the move decoder
    jrmd_if.host              link,
    // User request
    input  wire  logic        req,
    input  wire  logic        req_ccw,
    input  wire  logic        req_reg,
    input  wire  logic        req_cur_en,
    input  wire  logic [31:0] req_speed,
    input  wire  logic [15:0] req_accel,
    input  wire  logic [15:0] req_decel,
    input  wire  logic [15:0] req_current,
    input  wire  logic [15:0] req_jerk,
    input  wire  logic [31:0] req_stop_dist,
    input  wire  logic [31:0] req_min_dist,
    // User answer
    output logic              busy,
    output logic              done,
    output logic              done_err,
    output logic              done_move
);
    import jrmd_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b10
    } jrmd_hstate_t;

    jrmd_hstate_t state_ff;
    jrmd_words_t  words_ff;
    jrmd_words_t  nxt_words;
    logic         done_ff;
    logic         done_err_ff;
    logic         done_move_ff;

    // Block assembly; unused jog words 2 and 3 are simply sent as zero.
    always_comb begin
        nxt_words = '0;
        nxt_words[W_OPCODE] = req_ccw ? OP_JOG_CCW : OP_JOG_CW;
        nxt_words[W_MODE][MODE_SEL_HI:MODE_SEL_LO] = req_reg ? MODE_REG : MODE_JOG;
        nxt_words[W_SPEED_HI] = req_speed[31:16];
        nxt_words[W_SPEED_LO] = req_speed[15:0];
        nxt_words[W_ACCEL] = req_accel;
        nxt_words[W_DECEL] = req_decel;
        if (req_reg) begin
            nxt_words[W_STOP_HI] = req_stop_dist[31:16];
            nxt_words[W_STOP_LO] = req_stop_dist[15:0];
            nxt_words[W_MINREG_HI] = req_min_dist[31:16];
            nxt_words[W_MINREG_LO] = req_min_dist[15:0];
        end else begin
            nxt_words[W_MODE][MODE_CUR_BIT] = req_cur_en;
            nxt_words[W_CURRENT] = req_current;
            nxt_words[W_JERK] = req_jerk;
        end
    end

    // Requests arriving while busy are ignored.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= H_IDLE;
            words_ff <= '0;
        end else begin
            case (state_ff)
                H_IDLE: begin
                    if (req) begin
                        words_ff <= nxt_words;
                        state_ff <= H_SEND;
                    end
                end
                H_SEND: begin
                    state_ff <= H_WAIT;
                end
                H_WAIT: begin
                    if (link.resp_valid) begin
                        state_ff <= H_IDLE;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_ff      <= 1'b0;
            done_err_ff  <= 1'b0;
            done_move_ff <= 1'b0;
        end else begin
            done_ff      <= state_ff == H_WAIT && link.resp_valid;
            done_err_ff  <= state_ff == H_WAIT && link.resp_err;
            done_move_ff <= state_ff == H_WAIT && link.resp_move;
        end
    end

    assign link.cmd_valid = state_ff == H_SEND;
    assign link.cmd_words = words_ff;
    assign busy           = state_ff != H_IDLE;
    assign done           = done_ff;
    assign done_err       = done_err_ff;
    assign done_move      = done_move_ff;
endmodule

/* dv/jrmd_properties.sv */
// Concurrent checks on the link between the command source and the move decoder.
`timescale 1ns/1ps
module jrmd_properties (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Link signals
    input wire logic                  cmd_valid,
    input wire jrmd_pkg::jrmd_words_t cmd_words,
    input wire logic                  resp_valid,
    input wire logic                  resp_err,
    input wire logic                  resp_move
);
    import jrmd_pkg::*;
    logic        jog;
    logic        jg;
    logic        rg;
    logic [31:0] speed;
    assign jog = cmd_valid && (cmd_words[W_OPCODE] == OP_JOG_CW
                               || cmd_words[W_OPCODE] == OP_JOG_CCW);
    assign jg = jog && cmd_words[W_MODE][MODE_SEL_HI:MODE_SEL_LO] == MODE_JOG;
    assign rg = jog && cmd_words[W_MODE][MODE_SEL_HI:MODE_SEL_LO] == MODE_REG;
    assign speed = {cmd_words[W_SPEED_HI], cmd_words[W_SPEED_LO]};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A missing or early answer would hang the host, so the latency is pinned exactly.
    property p_answer; cmd_valid |-> ##3 resp_valid; endproperty
    property p_stray; resp_valid |-> $past(cmd_valid, 3); endproperty
    property p_pulse; resp_valid |=> !resp_valid; endproperty
    property p_flags; !resp_valid |-> !resp_err && !resp_move; endproperty
    property p_excl; resp_valid |-> !(resp_err && resp_move); endproperty
    property p_mode; jog |-> jg || rg; endproperty
    property p_speed; jog && speed > SPEED_MAX |-> ##3 resp_err; endproperty
    property p_rate;
        jog && (cmd_words[W_ACCEL] < RATE_MIN || cmd_words[W_ACCEL] > RATE_MAX
                || cmd_words[W_DECEL] < RATE_MIN || cmd_words[W_DECEL] > RATE_MAX)
        |-> ##3 resp_err;
    endproperty
    property p_jerk; jg && cmd_words[W_JERK] > JERK_MAX |-> ##3 resp_err; endproperty
    property p_dist;
        rg && ({cmd_words[W_STOP_HI], cmd_words[W_STOP_LO]} > DIST_MAX
               || {cmd_words[W_MINREG_HI], cmd_words[W_MINREG_LO]} > DIST_MAX)
        |-> ##3 resp_err;
    endproperty
    property p_cur;
        jg && cmd_words[W_MODE][MODE_CUR_BIT]
        && (cmd_words[W_CURRENT] < CUR_MIN || cmd_words[W_CURRENT] > CUR_MAX)
        |-> ##3 resp_err;
    endproperty
    a_answer: assert property (p_answer) else $error("No answer three cycles after block.");
    a_stray: assert property (p_stray) else $error("Answer without a block.");
    a_pulse: assert property (p_pulse) else $error("Answer longer than one cycle.");
    a_flags: assert property (p_flags) else $error("Result flag outside answer.");
    a_excl: assert property (p_excl) else $error("Move and error together.");
    a_mode: assert property (p_mode) else $error("Host sent a bad mode pattern.");
    a_speed: assert property (p_speed) else $error("Fast speed not refused.");
    a_rate: assert property (p_rate) else $error("Bad rate not refused.");
    a_jerk: assert property (p_jerk) else $error("Bad jerk not refused.");
    a_dist: assert property (p_dist) else $error("Bad distance not refused.");
    a_cur: assert property (p_cur) else $error("Bad current not refused.");
    c_move: cover property (resp_valid && resp_move);
    c_err: cover property (resp_valid && resp_err);
    c_reg: cover property (rg ##3 resp_move);
endmodule

/* dv/jog_registration_move_decoder_tb_top.sv */
// Self-checking bench joining host and decoder ends, plus a rule-breaking source.
`timescale 1ns/1ps
module jog_registration_move_decoder_tb_top;
    import jrmd_pkg::*;
    localparam logic [31:0] G_SP = 32'h00010000;
    localparam logic [15:0] G_R = 16'h0064;
    localparam logic [15:0] G_C = 16'h000A;
    logic        ref_clk, rst, req, r_ccw, r_reg, r_ce, busy, done, done_err, done_move;
    logic [31:0] r_sp, r_st, r_mn, start_spd, m_sp, m_st, m_mn, b_st, last_sp;
    logic [15:0] r_ac, r_dc, r_cu, r_jk, m_ac, m_dc, m_cu, m_jk;
    logic        m_start, m_ccw, m_reg, m_ce, cmd_error;
    int          n_errors, samples_checked;
    jrmd_if link();
    jrmd_if lb();
    jrmd_host u_jrmd_host (.ref_clk(ref_clk), .rst(rst), .link(link), .req(req),
        .req_ccw(r_ccw), .req_reg(r_reg), .req_cur_en(r_ce), .req_speed(r_sp),
        .req_accel(r_ac), .req_decel(r_dc), .req_current(r_cu), .req_jerk(r_jk),
        .req_stop_dist(r_st), .req_min_dist(r_mn), .busy(busy), .done(done),
        .done_err(done_err), .done_move(done_move));
    jrmd_device u_jrmd_device (.ref_clk(ref_clk), .rst(rst), .link(link),
        .start_speed(start_spd), .move_start(m_start), .move_ccw(m_ccw), .move_is_reg(m_reg),
        .move_speed(m_sp), .move_accel(m_ac), .move_decel(m_dc), .move_cur_en(m_ce),
        .move_current(m_cu), .move_jerk(m_jk), .move_stop_dist(m_st), .move_min_dist(m_mn),
        .cmd_error(cmd_error));
    jrmd_device u_jrmd_device_b (.ref_clk(ref_clk), .rst(rst), .link(lb),
        .start_speed(start_spd), .move_start(), .move_ccw(), .move_is_reg(),
        .move_speed(), .move_accel(), .move_decel(), .move_cur_en(), .move_current(),
        .move_jerk(), .move_stop_dist(b_st), .move_min_dist(), .cmd_error());
    jrmd_properties u_jrmd_properties (.ref_clk(ref_clk), .rst(rst),
        .cmd_valid(link.cmd_valid), .cmd_words(link.cmd_words), .resp_valid(link.resp_valid),
        .resp_err(link.resp_err), .resp_move(link.resp_move));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic do_move(input logic ccw, rg, ce, input logic [31:0] sp,
                           input logic [15:0] ac, dc, cu, jk, input logic [31:0] st, mn,
                           input logic err);
        int k;
        @(posedge ref_clk);
        req <= 1'h1;
        {r_ccw, r_reg, r_ce, r_sp, r_ac, r_dc, r_cu, r_jk, r_st, r_mn}
            <= {ccw, rg, ce, sp, ac, dc, cu, jk, st, mn};
        @(posedge ref_clk);
        req <= 1'h0;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (link.resp_valid !== 1'h1 && k < 8);
        // The answer is visible from just after the second edge past the capture edge.
        chk(k, 3);
        chk(m_start, !err);
        chk(cmd_error, err);
        if (err) begin
            chk(m_sp, last_sp);
        end else begin
            last_sp = sp;
            chk(m_ccw, ccw);
            chk(m_reg, rg);
            chk(m_sp, sp);
            chk(m_ac, ac);
            chk(m_dc, dc);
            chk(m_ce, ce && !rg);
            chk(m_cu, (ce && !rg) ? cu : 16'h0000);
            chk(m_jk, rg ? 16'h0000 : jk);
            chk(m_st, rg ? st : 32'h00000000);
            chk(m_mn, rg ? mn : 32'h00000000);
        end
        @(posedge ref_clk);
        #1;
        chk({busy, done, done_err, done_move}, {1'h0, 1'h1, err, !err});
    endtask
    task automatic b_send(input logic [15:0] op, md, w23, input logic [1:0] exp);
        int k;
        jrmd_words_t w;
        w = '0;
        w[W_OPCODE] = op;
        w[W_MODE] = md;
        w[W_STOP_HI] = w23;
        w[W_STOP_LO] = w23;
        w[W_SPEED_LO] = 16'h1000;
        w[W_ACCEL] = 16'h0001;
        w[W_DECEL] = 16'h0001;
        @(posedge ref_clk);
        lb.cmd_valid <= 1'h1;
        lb.cmd_words <= w;
        @(posedge ref_clk);
        lb.cmd_valid <= 1'h0;
        lb.cmd_words <= ~w;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (lb.resp_valid !== 1'h1 && k < 8);
        // Here the capture edge is the last edge before the loop, so one edge fewer.
        chk(k, 2);
        chk({lb.resp_err, lb.resp_move}, exp);
        chk(b_st, 32'h00000000);
    endtask
    task automatic t_jogs();
        do_move(1'h0, 1'h0, 1'h1, SPEED_MAX, RATE_MIN, RATE_MAX, CUR_MAX, JERK_MAX, 0, 0, 1'h0);
        do_move(1'h1, 1'h0, 1'h0, start_spd, RATE_MAX, RATE_MIN, 0, 0, 0, 0, 1'h0);
    endtask
    task automatic t_regs();
        do_move(1'h0, 1'h1, 1'h0, G_SP, G_R, G_R, 0, 0, DIST_MAX, 0, 1'h0);
        do_move(1'h1, 1'h1, 1'h0, G_SP, G_R, G_R, 0, 0, 0, DIST_MAX, 1'h0);
    endtask
    task automatic t_refusals();
        do_move(1'h0, 1'h0, 1'h0, SPEED_MAX + 32'h1, G_R, G_R, G_C, 0, 0, 0, 1'h1);
        do_move(1'h1, 1'h0, 1'h0, start_spd - 32'h1, G_R, G_R, G_C, 0, 0, 0, 1'h1);
        do_move(1'h0, 1'h0, 1'h0, G_SP, 16'h0000, G_R, G_C, 0, 0, 0, 1'h1);
        do_move(1'h0, 1'h1, 1'h0, G_SP, G_R, RATE_MAX + 16'h1, 0, 0, 0, 0, 1'h1);
        do_move(1'h1, 1'h0, 1'h0, G_SP, G_R, G_R, G_C, JERK_MAX + 16'h1, 0, 0, 1'h1);
        do_move(1'h0, 1'h0, 1'h1, G_SP, G_R, G_R, CUR_MAX + 16'h1, 0, 0, 0, 1'h1);
        do_move(1'h0, 1'h0, 1'h1, G_SP, G_R, G_R, 16'h0000, 0, 0, 0, 1'h1);
        do_move(1'h0, 1'h1, 1'h0, G_SP, G_R, G_R, 0, 0, DIST_MAX + 32'h1, 0, 1'h1);
        do_move(1'h1, 1'h1, 1'h0, G_SP, G_R, G_R, 0, 0, 0, DIST_MAX + 32'h1, 1'h1);
        do_move(1'h0, 1'h0, 1'h1, G_SP, G_R, G_R, CUR_MIN, 0, 0, 0, 1'h0);
    endtask
    task automatic t_far_faults();
        b_send(OP_JOG_CW, 16'h0000, 16'hFFFF, 2'h1);
        b_send(OP_JOG_CCW, 16'h0040, 16'h0000, 2'h2);
        b_send(OP_JOG_CW, 16'h00C0, 16'h0000, 2'h2);
        b_send(16'h0004, 16'h0000, 16'h0000, 2'h0);
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        {rst, req, r_ccw, r_reg, r_ce} = 5'h10;
        {r_sp, r_st, r_mn, r_ac, r_dc, r_cu, r_jk} = '0;
        {lb.cmd_valid, lb.cmd_words} = '0;
        start_spd = 32'h000003E8;
        last_sp = 32'h00000000;
        n_errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        t_jogs();
        t_regs();
        t_refusals();
        t_far_faults();
        give_verdict();
    end
endmodule
